// *** isa_pkg.sv ***
// Package of constants for the interrupt source aggregator
package isa_pkg;
  localparam int NUM_LINES = 32;
  localparam int NUM_PRIO_LEVELS = 4;
  localparam int PRIO_W = 2;
  localparam int NUM_TIMERS = 4;
  localparam int NUM_GPIO = 12;
  localparam int LINE_TIMER = 0;
  localparam int LINE_CONTACTLESS_FRONTEND_IRQ = 2;
  localparam int LINE_EEPROM = 3;
  localparam int LINE_HOSTIF = 6;
  localparam int LINE_PMU = 9;
  localparam int LINE_SPIM = 10;
  localparam int LINE_I2CM = 11;
  localparam int LINE_PCR = 12;
  localparam int LINE_GPIO_COMMON = 13;
  localparam int LINE_GPIO_FIRST = 14;
  localparam logic [31:0] RESERVED_MASK = 32'hfc00_01b2;
  localparam logic [31:0] RST_PENDING = 32'h0000_0000;
  localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
  localparam logic [1:0] RST_PRIO = 2'h0;
  localparam logic [1:0] RST_MASK_LEVEL = 2'h0;
  // Trigger mode encodings per pin
  localparam logic [2:0] TRIG_RISE = 3'h0;
  localparam logic [2:0] TRIG_FALL = 3'h1;
  localparam logic [2:0] TRIG_BOTH = 3'h2;
  localparam logic [2:0] TRIG_HIGH = 3'h3;
  localparam logic [2:0] TRIG_LOW = 3'h4;
  localparam int TRIG_W = 3;
endpackage : isa_pkg

// *** isa_pin_detect.sv ***
// Per-pin synchroniser and programmable edge/level detector
`timescale 1ns/100ps
module isa_pin_detect (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic pin_in,
  input wire logic [2:0] trig_mode,
  output logic irq_req
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic lvl_r;
  logic rise;
  logic fall;
  logic agree;
  logic hit;

  // Three flops; a change counts only once stages two and three agree
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      lvl_r <= 1'b0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (agree) begin
        lvl_r <= s3_r;
      end
    end
  end

  // Edges seen on the filtered level
  assign agree = (s2_r == s3_r);
  assign rise = agree && s3_r && !lvl_r;
  assign fall = agree && !s3_r && lvl_r;
  assign hit = (trig_mode == isa_pkg::TRIG_RISE) ? rise :
               (trig_mode == isa_pkg::TRIG_FALL) ? fall :
               (trig_mode == isa_pkg::TRIG_BOTH) ? (rise || fall) :
               (trig_mode == isa_pkg::TRIG_HIGH) ? lvl_r :
               (trig_mode == isa_pkg::TRIG_LOW) ? !lvl_r : 1'b0;

  // Registered request, one cycle for edges, held for levels
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= hit;
    end
  end
endmodule : isa_pin_detect

// *** isa_irq_aggregator.sv ***
// Interrupt source aggregator with pending, priority masking and NMI
`timescale 1ns/100ps
// Overview of operation
// - Thirty-two separate numbered request lines to core
// - Four priority levels, mask at or below level
// - Software can set any line pending
// - Watchdog drives unmaskable NMI output
// - NMI comes only from internal watchdog
// - Line 0 carries all four timers
// - Line 2 contactless, line 3 EEPROM
// - Line 6 carries active host buffer request
// - Line 9 carries power management events
// - Line 10 SPI master, 11 I2C master
// - Line 12 carries power/clock/reset unit events
// - Line 13 is OR of pin requests
// - Lines 14-25 pin requests with trigger modes
module isa_irq_aggregator #(
  parameter int NUM_LINES = isa_pkg::NUM_LINES,
  parameter int NUM_GPIO = isa_pkg::NUM_GPIO,
  parameter int NUM_TIMERS = isa_pkg::NUM_TIMERS
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [3:0] timer_irq,
  input wire logic contactless_frontend_irq,
  input wire logic eeprom_ctrl_irq,
  input wire logic [3:0] host_buf_irq,
  input wire logic [3:0] pmu_event,
  input wire logic spim_buf_irq,
  input wire logic i2cm_buf_irq,
  input wire logic [4:0] pcr_event,
  input wire logic [11:0] gpio_pin,
  input wire logic [35:0] gpio_trig_mode,
  input wire logic watchdog_timer_irq,
  input wire logic [31:0] irq_enable,
  input wire logic [63:0] irq_prio,
  input wire logic [1:0] mask_level,
  input wire logic [31:0] sw_set_pending,
  input wire logic [31:0] clr_pending,
  output logic [31:0] irq_pending,
  output logic [31:0] irq_request,
  output logic nmi_request,
  output logic [4:0] irq_line_number,
  output logic irq_valid
);
  typedef enum logic [0:0] {ISA_IDLE, ISA_ACTIVE} isa_state_e;

  logic [31:0] hw_lines;
  logic [31:0] pending_r;
  logic [31:0] pending_nxt;
  logic [31:0] request_r;
  logic [31:0] eligible;
  logic [11:0] pin_irq;
  logic timer_line;
  logic gpio_common;
  logic nmi_r;
  logic [4:0] best_idx;
  logic best_found;
  logic [4:0] line_r;
  logic valid_r;
  isa_state_e state_r;
  isa_state_e state_nxt;

  // Priority of line n from the packed field
  function automatic logic [1:0] prio_of(input logic [63:0] p, input int n);
    prio_of = p[2*n +: 2];
  endfunction : prio_of

  // One detector per general-purpose pin
  genvar g;
  generate
    for (g = 0; g < NUM_GPIO; g++) begin : gen_pin
      isa_pin_detect u_det (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .pin_in(gpio_pin[g]),
        .trig_mode(gpio_trig_mode[3*g +: 3]),
        .irq_req(pin_irq[g])
      );
    end
  endgenerate

  // Source-to-line mapping
  assign timer_line = |timer_irq;
  assign gpio_common = |pin_irq;
  always_comb begin
    hw_lines = 32'h0000_0000;
    hw_lines[isa_pkg::LINE_TIMER] = timer_line;
    hw_lines[isa_pkg::LINE_CONTACTLESS_FRONTEND_IRQ] = contactless_frontend_irq;
    hw_lines[isa_pkg::LINE_EEPROM] = eeprom_ctrl_irq;
    hw_lines[isa_pkg::LINE_HOSTIF] = |host_buf_irq;
    hw_lines[isa_pkg::LINE_PMU] = |pmu_event;
    hw_lines[isa_pkg::LINE_SPIM] = spim_buf_irq;
    hw_lines[isa_pkg::LINE_I2CM] = i2cm_buf_irq;
    hw_lines[isa_pkg::LINE_PCR] = |pcr_event;
    hw_lines[isa_pkg::LINE_GPIO_COMMON] = gpio_common;
    hw_lines[isa_pkg::LINE_GPIO_FIRST +: 12] = pin_irq;
    hw_lines = hw_lines & ~isa_pkg::RESERVED_MASK;
  end

  // Pending: set wins over clear; level sources keep it set
  assign pending_nxt = (pending_r & ~clr_pending) | hw_lines | sw_set_pending;

  // Eligible lines must beat the current masking level
  always_comb begin
    for (int n = 0; n < 32; n++) begin
      eligible[n] = pending_r[n] && irq_enable[n] &&
                    (prio_of(irq_prio, n) > mask_level);
    end
  end

  // Highest priority eligible line, lowest number on a tie
  always_comb begin
    best_idx = 5'h00;
    best_found = 1'b0;
    for (int n = 31; n >= 0; n--) begin
      if (eligible[n] && (!best_found ||
          prio_of(irq_prio, n) >= prio_of(irq_prio, int'(best_idx)))) begin
        best_idx = 5'(n);
        best_found = 1'b1;
      end
    end
  end

  // Presentation state follows whether anything is eligible
  always_comb begin
    case (state_r)
      ISA_IDLE: state_nxt = best_found ? ISA_ACTIVE : ISA_IDLE;
      ISA_ACTIVE: state_nxt = best_found ? ISA_ACTIVE : ISA_IDLE;
      default: state_nxt = ISA_IDLE;
    endcase
  end

  // Pending and per-line request registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pending_r <= isa_pkg::RST_PENDING;
      request_r <= 32'h0000_0000;
    end else begin
      pending_r <= pending_nxt;
      request_r <= eligible;
    end
  end

  // Watchdog straight to NMI, no masking, no pin path
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      nmi_r <= 1'b0;
    end else begin
      nmi_r <= watchdog_timer_irq;
    end
  end

  // Winner line number for the core
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      line_r <= 5'h00;
      valid_r <= 1'b0;
      state_r <= ISA_IDLE;
    end else begin
      state_r <= state_nxt;
      valid_r <= (state_nxt == ISA_ACTIVE);
      line_r <= best_idx;
    end
  end

  assign irq_pending = pending_r;
  assign irq_request = request_r;
  assign nmi_request = nmi_r;
  assign irq_line_number = line_r;
  assign irq_valid = valid_r;
endmodule : isa_irq_aggregator

// *** isa_irq_checker.sv ***
// Port checker for the interrupt source aggregator
`timescale 1ns/100ps
module isa_irq_checker (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [3:0] timer_irq,
  input wire logic eeprom_ctrl_irq,
  input wire logic watchdog_timer_irq,
  input wire logic [31:0] irq_enable,
  input wire logic [63:0] irq_prio,
  input wire logic [1:0] mask_level,
  input wire logic [31:0] sw_set_pending,
  input wire logic [31:0] irq_pending,
  input wire logic [31:0] irq_request,
  input wire logic nmi_request,
  input wire logic [4:0] irq_line_number,
  input wire logic irq_valid
);
  // One clock domain, so clocking and reset are set once
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  timer_or_a: assert property (|timer_irq |=> irq_pending[0])
    else $error("timer line not pending");
  eeprom_line_a: assert property (eeprom_ctrl_irq |=> irq_pending[3])
    else $error("eeprom line not pending");
  nmi_follow_a: assert property (watchdog_timer_irq |=> nmi_request)
    else $error("nmi missing");
  nmi_quiet_a: assert property (!watchdog_timer_irq |=> !nmi_request)
    else $error("nmi without watchdog");
  prio_pass_a: assert property (irq_pending[3] && irq_enable[3] && irq_prio[7:6] > mask_level
    |=> irq_request[3])
    else $error("unmasked request missing");
  prio_block_a: assert property (irq_prio[7:6] <= mask_level |=> !irq_request[3])
    else $error("masked request seen");
  sw_set_a: assert property (sw_set_pending[31] |=> irq_pending[31])
    else $error("software set lost");
  rsvd_quiet_a: assert property ((irq_pending & ~$past(irq_pending) & ~$past(sw_set_pending)
    & isa_pkg::RESERVED_MASK) == 32'h0)
    else $error("reserved line set by hardware");
  // Presented line must be one that is really requesting
  winner_live_a: assert property (irq_valid |-> irq_request[irq_line_number])
    else $error("presented line not requesting");
endmodule : isa_irq_checker
bind isa_irq_aggregator isa_irq_checker u_chk (.ref_clk, .nrst, .timer_irq, .eeprom_ctrl_irq,
  .watchdog_timer_irq, .irq_enable, .irq_prio, .mask_level, .sw_set_pending, .irq_pending,
  .irq_request, .nmi_request, .irq_line_number, .irq_valid);

// *** isa_core_model.sv ***
// Core model: acknowledges the winning line by clearing it
`timescale 1ns/100ps
module isa_core_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ack_en,
  input wire logic irq_valid,
  input wire logic [4:0] irq_line_number,
  output logic [31:0] clr_pending
);
  // One-cycle clear pulse, then one idle cycle; the next pulse still names the previous winner, as line number lags two cycles
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) clr_pending <= 32'h0;
    else if (ack_en && irq_valid && clr_pending == 32'h0) clr_pending <= 32'h1 << irq_line_number;
    else clr_pending <= 32'h0;
  end
endmodule : isa_core_model

// *** testbench.sv ***
// Self-checking bench for the interrupt source aggregator
`timescale 1ns/100ps
module testbench;
  logic ref_clk = 0, nrst = 0, wdt = 0, ack_en = 1, nmi, valid;
  logic [20:0] src = 0;
  logic [11:0] pins = 0;
  logic [35:0] trig = '1;
  logic [31:0] en = '1, sw = 0, clr, pend, req;
  logic [63:0] prio = '1;
  logic [1:0] mask = 0;
  logic [4:0] num;
  int n_errors = 0, n_tests = 0;
  isa_irq_aggregator u_dut (.ref_clk, .nrst, .timer_irq(src[20:17]),
    .contactless_frontend_irq(src[16]), .eeprom_ctrl_irq(src[15]), .host_buf_irq(src[14:11]),
    .pmu_event(src[10:7]), .spim_buf_irq(src[6]), .i2cm_buf_irq(src[5]), .pcr_event(src[4:0]),
    .gpio_pin(pins), .gpio_trig_mode(trig), .watchdog_timer_irq(wdt), .irq_enable(en),
    .irq_prio(prio), .mask_level(mask), .sw_set_pending(sw), .clr_pending(clr),
    .irq_pending(pend), .irq_request(req), .nmi_request(nmi), .irq_line_number(num),
    .irq_valid(valid));
  isa_core_model u_core (.ref_clk, .nrst, .ack_en, .irq_valid(valid), .irq_line_number(num),
    .clr_pending(clr));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  // Each source alone lands on its own line only
  task automatic t_map();
    int line;
    for (int i = 0; i < 21; i++) begin
      line = i < 5 ? 12 : i < 7 ? 16 - i : i < 11 ? 9 : i < 15 ? 6 : i < 17 ? 18 - i : 0;
      ack_en = 0;
      src[i] = 1;
      cyc(1);
      src[i] = 0;
      cyc(1);
      chk(pend, 32'h1 << line);
      ack_en = 1;
      cyc(6);
      chk(pend, 32'h0);
    end
  endtask : t_map
  // Every pin with a trigger mode; common line must join in
  task automatic t_gpio();
    for (int p = 0; p < 12; p++) begin
      ack_en = 0;
      trig[3*p +: 3] = 3'(p % 5);
      pins[p] = 1;
      cyc(6);
      pins[p] = 0;
      cyc(8);
      chk(pend, 32'h2000 | 32'h1 << (14 + p));
      trig = '1;
      ack_en = 1;
      cyc(14);
      chk(pend, 32'h0);
    end
  endtask : t_gpio
  // Full priority/mask grid, strictly greater wins; reserved lines by software
  task automatic t_prio();
    ack_en = 0;
    en = 32'h8;
    sw = 32'h8000_000a;
    cyc(1);
    sw = 0;
    for (int m = 0; m < 4; m++) begin
      for (int q = 0; q < 4; q++) begin
        mask = 2'(m);
        prio[7:6] = 2'(q);
        cyc(2);
        chk(req, q > m ? 32'h8 : 32'h0);
      end
    end
    chk(pend, 32'h8000_000a);
    en = '1;
    prio = '1;
    mask = 0;
    ack_en = 1;
    cyc(20);
    chk(pend, 32'h0);
  endtask : t_prio
  // Winner: higher priority first, lowest line on a tie, valid drops once served
  task automatic t_win();
    ack_en = 0;
    prio[7:6] = 2'h1;
    prio[21:20] = 2'h2;
    sw = 32'h0000_0408;
    cyc(1);
    sw = 0;
    cyc(2);
    chk({27'h0, num}, 32'h0000_000a);
    chk({31'h0, valid}, 32'h1);
    prio = '1;
    cyc(2);
    chk({27'h0, num}, 32'h0000_0003);
    ack_en = 1;
    cyc(12);
    chk({31'h0, valid}, 32'h0);
    chk(pend, 32'h0);
  endtask : t_win
  // Watchdog reaches the core even with everything masked
  task automatic t_nmi();
    en = 0;
    mask = 2'h3;
    wdt = 1;
    cyc(2);
    chk({31'h0, nmi}, 32'h1);
    wdt = 0;
    cyc(2);
    chk({31'h0, nmi}, 32'h0);
  endtask : t_nmi
  task automatic complete_run();
    if (n_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    cyc(8);
    nrst = 1;
    cyc(2);
    t_map();
    t_gpio();
    t_prio();
    t_win();
    t_nmi();
    complete_run();
  end
  // Scenarios need about 590 cycles; cut a hang well beyond that
  initial begin
    #20000;
    n_errors++;
    complete_run();
  end
endmodule : testbench
